// ### core/sgh_bank.sv
// signaling mode and common highway control bank for eight framers
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
//
// Contract
// - transparent_signaling 0: insert and extract signaling
// - ds1: f/g bits choose voice or data
// - transparent_signaling 1: pass data, all data channels
// - stomp 0: forward received signaling unchanged
// - ds1 stomp: extract first, then force ones on voice channels
// - cept stomp: nibble 0000 becomes 1111
// - assoc mode: 16-bit highway channels
// - freeze bit holds receive signaling buffer
// - ds1: enable channel 24 message signaling
// - split: f/g from registers, abcd highway
// - split: copy transmit f/g to receive
// - cept: auto slot 16 alarm on lof
// - cept squelch: alarm in slot 16
// - pll mode 0: 8 khz from low reference
// - pll mode 1: 32 khz from fourfold reference
// - clock mode 0: clock equals data rate
// - bits 2-3 select shared highway rate
// - highway control register resets to zero
// - signaling mode register resets to zero

module sgh_bank #(
  parameter int NUM_FRAMERS = 8                           // framers served by this bank
) (
  // clock and reset
  input  wire logic                                  clock_i,
  input  wire logic                                  rst_n_i,
  // register port
  input  wire logic [sgh_pkg::ADDR_W-1:0]            addr_i,
  input  wire logic [7:0]                            wdata_i,
  input  wire logic                                  wr_i,
  input  wire logic                                  rd_i,
  output logic      [7:0]                            rdata_o,
  // framer side
  input  wire sgh_pkg::sgh_frm_in_s [NUM_FRAMERS-1:0] frm_i,
  input  wire logic [NUM_FRAMERS-1:0]                pll_reference_clock_i,
  output sgh_pkg::sgh_ctl_s    [NUM_FRAMERS-1:0]     ctl_o,
  output sgh_pkg::sgh_rx_out_s [NUM_FRAMERS-1:0]     rx_o,
  output logic      [NUM_FRAMERS-1:0]                divided_reference_output_o
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  // three address bits pick the framer, so more than eight cannot be reached
  if (NUM_FRAMERS < 1 || NUM_FRAMERS > 8) begin : g_bad_count
    $error("NUM_FRAMERS must be 1 to 8");
  end

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    sgh_pkg::sgh_frm_s [NUM_FRAMERS-1:0] fr;               // per-framer state
    logic [7:0]                          rdata;            // read answer
  } sgh_state_s;

  sgh_state_s st_ff;                                       // registered state
  sgh_state_s nxt_st;                                      // next state
  logic [1:0] rst_sync_ff;                                 // reset release chain
  logic       rst_n;                                       // synchronised reset

  // ****************************************************************
  // helpers
  // ****************************************************************
  // divide ratio follows the line format; the same ratio gives 8 khz from the
  // low reference and 32 khz from the fourfold one
  function automatic logic [8:0] div_ratio(input logic cept);
    div_ratio = cept ? sgh_pkg::DIV_CEPT : sgh_pkg::DIV_DS1;
  endfunction

  // decode both control registers into the control carrier
  function automatic sgh_pkg::sgh_ctl_s decode(input logic [7:0] sm,
                                               input logic [7:0] hc,
                                               input logic       cept,
                                               input logic       lof);
    sgh_pkg::sgh_ctl_s c;
    c = '0;
    c.insert_extract = !sm[sgh_pkg::B_TRANSPARENT];
    c.assoc          = sm[sgh_pkg::B_ASSOC];
    c.assoc_src      = !sm[sgh_pkg::B_TRANSPARENT] && sm[sgh_pkg::B_ASSOC];
    c.msg_sig        = !cept && sm[sgh_pkg::B_MSG_SIG];
    c.split          = !cept && sm[sgh_pkg::B_SPLIT]
                       && sm[sgh_pkg::B_ASSOC];
    c.ts16_ais       = cept && (sm[sgh_pkg::B_SQUELCH]
                       || (sm[sgh_pkg::B_AUTO_AIS] && lof));
    c.pll_high       = hc[sgh_pkg::B_PLL_RATE];
    c.clk_eq_rate    = !hc[sgh_pkg::B_CLK_MODE];
    c.rate           = sgh_pkg::sgh_rate_e'({hc[sgh_pkg::B_RATE_HI],
                                             hc[sgh_pkg::B_RATE_LO]});
    return c;
  endfunction

  // ****************************************************************
  // reset release
  // ****************************************************************
  // asserts at once, releases two clocks later so no framer sees a ragged edge
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_ff[1];

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  // one pass per framer; nothing crosses from one framer's slot to another
  always_comb begin
    logic [2:0] sel;
    logic [1:0] ofs;
    logic       ext;
    logic       voice;
    logic [1:0] fg;
    logic [3:0] nib;
    logic [8:0] lim;
    sel    = addr_i[sgh_pkg::FRM_SEL_LSB +: 3];
    ofs    = addr_i[1:0];
    ext    = 1'b0;
    voice  = 1'b0;
    fg     = 2'h0;
    nib    = 4'h0;
    lim    = 9'h0;
    nxt_st = st_ff;
    nxt_st.rdata = 8'h00;                                  // answer only after a read

    for (int i = 0; i < NUM_FRAMERS; i++) begin
      // register writes, each framer decodes its own slot
      if (wr_i && sel == 3'(i)) begin
        if (ofs == sgh_pkg::OFS_SIG_MODE) begin
          nxt_st.fr[i].sig_mode = wdata_i;
        end
        if (ofs == sgh_pkg::OFS_HWY_CTL) begin
          nxt_st.fr[i].hwy_ctl = wdata_i;
        end
      end

      // register reads; unmapped offsets answer zero
      if (rd_i && sel == 3'(i)) begin
        case (ofs)
          sgh_pkg::OFS_SIG_MODE: nxt_st.rdata = st_ff.fr[i].sig_mode;
          sgh_pkg::OFS_HWY_CTL:  nxt_st.rdata = st_ff.fr[i].hwy_ctl;
          sgh_pkg::OFS_STATUS:   nxt_st.rdata = {2'h0, st_ff.fr[i].ctl.ts16_ais,
                                                 st_ff.fr[i].div_out,
                                                 st_ff.fr[i].sig_buf};
          default:               nxt_st.rdata = 8'h00;
        endcase
      end

      // control decode from the values now being stored
      nxt_st.fr[i].ctl = decode(nxt_st.fr[i].sig_mode, nxt_st.fr[i].hwy_ctl,
                                frm_i[i].cept, frm_i[i].ts16_lof);

      // receive signaling path
      ext = !st_ff.fr[i].sig_mode[sgh_pkg::B_TRANSPARENT];
      // split mode borrows the transmit f/g so both directions agree on format
      fg  = st_ff.fr[i].ctl.split ? frm_i[i].tx_fg : frm_i[i].rx_fg;
      // only ds1 with active signaling has voice channels at all
      voice = ext && !frm_i[i].cept && (fg != sgh_pkg::FG_DATA);
      nib   = frm_i[i].nib;
      if (ext && st_ff.fr[i].sig_mode[sgh_pkg::B_STOMP]) begin
        if (!frm_i[i].cept) begin
          // extraction below uses the raw nibble, stomp only hits the line copy
          if (voice) begin
            nib = sgh_pkg::NIB_ONES;
          end
        end else if (frm_i[i].nib == sgh_pkg::NIB_ZERO) begin
          nib = sgh_pkg::NIB_ONES;
        end
      end
      nxt_st.fr[i].rx.valid    = frm_i[i].nib_valid;
      nxt_st.fr[i].rx.voice    = voice;
      nxt_st.fr[i].rx.fg_used  = fg;
      if (frm_i[i].nib_valid) begin
        nxt_st.fr[i].rx.line_nib = nib;
        // freeze keeps the last good value, useful during a line fault
        if (ext && !st_ff.fr[i].sig_mode[sgh_pkg::B_FREEZE]
            && (voice || frm_i[i].cept)) begin
          nxt_st.fr[i].sig_buf = frm_i[i].nib;
        end
      end

      // reference divide-down; edge taken from the second sync stage only
      nxt_st.fr[i].ref_sync = {st_ff.fr[i].ref_sync[0], pll_reference_clock_i[i]};
      nxt_st.fr[i].ref_prev = st_ff.fr[i].ref_sync[1];
      lim = div_ratio(frm_i[i].cept) - 9'h1;
      if (st_ff.fr[i].div_cnt > lim) begin
        // a switch from cept to ds1 can strand the count past the new end
        nxt_st.fr[i].div_cnt = 9'h0;
      end else if (st_ff.fr[i].ref_sync[1] && !st_ff.fr[i].ref_prev) begin
        if (st_ff.fr[i].div_cnt >= lim) begin
          nxt_st.fr[i].div_cnt = 9'h0;
        end else begin
          nxt_st.fr[i].div_cnt = st_ff.fr[i].div_cnt + 9'h1;
        end
      end
      // square wave: high for the first half of each period
      nxt_st.fr[i].div_out = nxt_st.fr[i].div_cnt < {1'b0, lim[8:1]} + 9'h1;
    end
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  // reset puts both control registers at zero: signaling on, every option off
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_FRAMERS; i++) begin
        st_ff.fr[i]          <= '0;
        st_ff.fr[i].sig_mode <= sgh_pkg::SIG_MODE_RST;
        st_ff.fr[i].hwy_ctl  <= sgh_pkg::HWY_CTL_RST;
        st_ff.fr[i].ctl      <= '0;
      end
      st_ff.rdata <= 8'h00;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // outputs, all straight from state
  // ****************************************************************
  assign rdata_o = st_ff.rdata;

  always_comb begin
    for (int i = 0; i < NUM_FRAMERS; i++) begin
      ctl_o[i]                      = st_ff.fr[i].ctl;
      rx_o[i]                       = st_ff.fr[i].rx;
      divided_reference_output_o[i] = st_ff.fr[i].div_out;
    end
  end

  // ****************************************************************
  // assertions on framer 0
  // ****************************************************************
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n);

  logic w_sig0;                                            // write to framer 0 mode
  logic w_hwy0;                                            // write to framer 0 highway
  logic w_sig1;                                            // write to framer 1 mode
  assign w_sig0 = wr_i && addr_i == {3'h0, sgh_pkg::OFS_SIG_MODE};
  assign w_hwy0 = wr_i && addr_i == {3'h0, sgh_pkg::OFS_HWY_CTL};
  assign w_sig1 = wr_i && addr_i == {3'h1, sgh_pkg::OFS_SIG_MODE};

  chk_transp_all_data: assert property (w_sig0 && wdata_i[0] ##1 !w_sig0 ##1 1'b1
      |-> !ctl_o[0].insert_extract && !(rx_o[0].valid && rx_o[0].voice))
    else $error("transparent mode left signaling active");
  chk_insert_on: assert property (w_sig0 && !wdata_i[0] |=> ctl_o[0].insert_extract)
    else $error("signaling not enabled after transparent_signaling cleared");
  chk_stomp_off: assert property (frm_i[0].nib_valid && !st_ff.fr[0].sig_mode[1]
      |=> rx_o[0].line_nib == $past(frm_i[0].nib))
    else $error("nibble altered with stomp off");
  chk_cept_stomp: assert property (frm_i[0].nib_valid && frm_i[0].cept
      && frm_i[0].nib == 4'h0 && st_ff.fr[0].sig_mode[1:0] == 2'b10
      |=> rx_o[0].line_nib == 4'hf)
    else $error("cept zero nibble not stomped");
  chk_ds1_stomp: assert property (frm_i[0].nib_valid && !frm_i[0].cept
      && st_ff.fr[0].sig_mode[1:0] == 2'b10 && frm_i[0].rx_fg != 2'h0
      && !st_ff.fr[0].ctl.split |=> rx_o[0].line_nib == 4'hf)
    else $error("ds1 voice nibble not forced to ones");
  chk_freeze_hold: assert property (st_ff.fr[0].sig_mode[3] && !w_sig0
      |=> $stable(st_ff.fr[0].sig_buf))
    else $error("frozen buffer changed");
  chk_assoc_width: assert property (w_sig0 |=> ctl_o[0].assoc == $past(wdata_i[2]))
    else $error("assoc flag does not follow write");
  chk_rate_field: assert property (w_hwy0 |=> ctl_o[0].rate == $past(wdata_i[3:2])
      && ctl_o[0].clk_eq_rate == !$past(wdata_i[1]))
    else $error("highway rate or clock mode wrong");
  chk_squelch: assert property (frm_i[0].cept && st_ff.fr[0].sig_mode[7] && !w_sig0
      |=> ctl_o[0].ts16_ais)
    else $error("squelch did not raise slot 16 alarm");
  chk_auto_ais: assert property (frm_i[0].cept && frm_i[0].ts16_lof
      && st_ff.fr[0].sig_mode[6] && !w_sig0 |=> ctl_o[0].ts16_ais)
    else $error("loss of alignment did not raise alarm");
  chk_msg_split: assert property (!frm_i[0].cept && !w_sig0
      && st_ff.fr[0].sig_mode[5:4] == 2'b11 && st_ff.fr[0].sig_mode[2]
      |=> ctl_o[0].msg_sig && ctl_o[0].split)
    else $error("message or split mode missing");
  chk_split_fg: assert property (st_ff.fr[0].ctl.split && frm_i[0].nib_valid
      |=> rx_o[0].fg_used == $past(frm_i[0].tx_fg))
    else $error("split mode did not use transmit f/g");
  chk_div_wrap: assert property (st_ff.fr[0].div_cnt
      <= div_ratio(frm_i[0].cept) - 9'h1 || $changed(frm_i[0].cept))
    else $error("divider count beyond ratio");
  chk_readback: assert property (w_sig0 ##1 rd_i && !wr_i && addr_i == 5'h00
      |=> rdata_o == $past(wdata_i, 2))
    else $error("readback mismatch");
  chk_isolation: assert property (w_sig1 && !w_sig0
      |=> $stable(st_ff.fr[0].sig_mode))
    else $error("write leaked into framer 0");

  cov_stomp_cept: cover property (rx_o[0].valid && frm_i[0].cept && rx_o[0].line_nib == 4'hf);
  cov_freeze: cover property (st_ff.fr[0].sig_mode[3] && rx_o[0].valid);
  cov_div_wrap: cover property (st_ff.fr[0].div_cnt == 9'h0 ##1 st_ff.fr[0].div_cnt == 9'h1);
  cov_ais: cover property (ctl_o[0].ts16_ais);

endmodule

// ### include/sgh_pkg.sv
// package: constants, carriers and state types for the signaling and highway control bank
package sgh_pkg;

  // ****************************************************************
  // clock and bus geometry
  // ****************************************************************
  localparam int CLK_PERIOD_NS  = 25;            // device clock, 40 mhz
  localparam int ADDR_W         = 5;             // {framer[2:0], reg[1:0]}
  localparam int FRM_SEL_LSB    = 2;             // framer index position in address

  // ****************************************************************
  // register offsets inside one framer slot
  // ****************************************************************
  localparam logic [1:0] OFS_SIG_MODE = 2'h0;    // signaling_mode_control
  localparam logic [1:0] OFS_HWY_CTL  = 2'h1;    // highway_common_control_a
  localparam logic [1:0] OFS_STATUS   = 2'h2;    // read-only signaling state

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] SIG_MODE_RST = 8'h00;
  localparam logic [7:0] HWY_CTL_RST  = 8'h00;

  // ****************************************************************
  // signaling_mode_control field positions
  // ****************************************************************
  localparam int B_TRANSPARENT = 0;              // transparent_signaling
  localparam int B_STOMP       = 1;              // receive stomp
  localparam int B_ASSOC       = 2;              // associated_signaling_mode
  localparam int B_FREEZE      = 3;              // receive_signaling_freeze
  localparam int B_MSG_SIG     = 4;              // message_signaling_enable
  localparam int B_SPLIT       = 5;              // split_format_signaling
  localparam int B_AUTO_AIS    = 6;              // auto_system_slot16_alarm
  localparam int B_SQUELCH     = 7;              // transmit_slot16_squelch

  // ****************************************************************
  // highway_common_control_a field positions
  // ****************************************************************
  localparam int B_PLL_RATE    = 0;              // pll_reference_rate_select
  localparam int B_CLK_MODE    = 1;              // highway_clock_mode
  localparam int B_RATE_LO     = 2;              // highway_rate_select_lo
  localparam int B_RATE_HI     = 3;              // highway_rate_select_hi

  // ****************************************************************
  // divide-down ratios: reference edges per output period
  // ****************************************************************
  localparam logic [8:0] DIV_DS1  = 9'h0c1;      // 193: 1.544 mhz -> 8 khz
  localparam logic [8:0] DIV_CEPT = 9'h100;      // 256: 2.048 mhz -> 8 khz

  // ****************************************************************
  // signaling nibble constants
  // ****************************************************************
  localparam logic [3:0] NIB_ZERO = 4'h0;
  localparam logic [3:0] NIB_ONES = 4'hf;
  localparam logic [1:0] FG_DATA  = 2'h0;        // f/g code marking a data channel

  // highway data rate codes
  typedef enum logic [1:0] {
    SGH_RATE_2M = 2'b00,
    SGH_RATE_4M = 2'b10,          // {hi, lo}: only the upper select bit set
    SGH_RATE_8M = 2'b01,          // {hi, lo}: only the lower select bit set
    SGH_RATE_RS = 2'b11
  } sgh_rate_e;

  // per-framer inputs from the framer core, same clock
  typedef struct packed {
    logic       cept;         // 1: cept line format, 0: ds1
    logic       ts16_lof;     // loss of slot 16 multiframe alignment
    logic       nib_valid;    // one received signaling nibble
    logic [3:0] nib;          // received abcd
    logic [1:0] tx_fg;        // f/g bits of the transmit signaling register
    logic [1:0] rx_fg;        // f/g bits of the receive signaling block
  } sgh_frm_in_s;

  // per-framer decoded control, registered
  typedef struct packed {
    logic      insert_extract; // signaling inserted and extracted
    logic      assoc;          // 16-bit highway channels
    logic      assoc_src;      // transmit signaling taken from system data
    logic      msg_sig;        // channel 24 message signaling
    logic      split;          // f/g from registers, abcd from highway
    logic      ts16_ais;       // alarm in system slot 16
    logic      pll_high;       // fourfold reference mode
    logic      clk_eq_rate;    // highway clock equals data rate
    sgh_rate_e rate;           // shared highway data rate
  } sgh_ctl_s;

  // per-framer receive signaling result, registered
  typedef struct packed {
    logic       valid;        // one-cycle pulse per nibble
    logic       voice;        // channel treated as voice
    logic [3:0] line_nib;     // nibble sent on in the line stream
    logic [1:0] fg_used;      // f/g used for extraction
  } sgh_rx_out_s;

  // per-framer state
  typedef struct packed {
    logic [7:0]  sig_mode;
    logic [7:0]  hwy_ctl;
    logic [3:0]  sig_buf;     // last extracted nibble
    logic [8:0]  div_cnt;
    logic        div_out;
    logic [1:0]  ref_sync;    // reference clock synchroniser
    logic        ref_prev;
    sgh_ctl_s    ctl;
    sgh_rx_out_s rx;
  } sgh_frm_s;

endpackage

// ### test/sgh_frm_model.sv
// partner model: framer core feeding nibbles, levels and reference clocks
`timescale 1ns/1ps
module sgh_frm_model (
  // clock
  input  wire logic                       clock_i,
  // toward the bank
  output sgh_pkg::sgh_frm_in_s [7:0]      frm_o,
  output logic                 [7:0]      ref_clk_o
);
  logic ref_q; // shared low-rate reference, free running
  // reference runs free at 200 ns, phase unrelated to the device clock
  initial begin
    frm_o = '0;
    ref_q = 1'b0;
    #37;
    forever #100 ref_q = ~ref_q;
  end
  assign ref_clk_o = {8{ref_q}};
  // line format and slot 16 alignment levels of one framer
  task set_lvl(input int i, input logic c, input logic l);
    @(posedge clock_i);
    frm_o[i].cept     <= c;
    frm_o[i].ts16_lof <= l;
  endtask
  // one nibble pulse; fields are scrambled once the pulse is over
  task send(input int i, input logic [3:0] n, input logic [1:0] tf, input logic [1:0] rf);
    @(posedge clock_i);
    frm_o[i].nib_valid <= 1'b1;
    frm_o[i].nib       <= n;
    frm_o[i].tx_fg     <= tf;
    frm_o[i].rx_fg     <= rf;
    @(posedge clock_i);
    frm_o[i].nib_valid <= 1'b0;
    frm_o[i].nib       <= ~n;
    frm_o[i].tx_fg     <= ~tf;
    frm_o[i].rx_fg     <= ~rf;
  endtask
endmodule

// ### test/tb.sv
// testbench for the signaling and highway control bank
`timescale 1ns/1ps
module tb;
  logic                              clock_i = 1'b0;
  logic                              rst_n_i = 1'b0;
  logic [4:0]                        addr_i  = '0;
  logic [7:0]                        wdata_i = '0;
  logic                              wr_i    = 1'b0;
  logic                              rd_i    = 1'b0;
  logic [7:0]                        rdata_o;
  sgh_pkg::sgh_frm_in_s  [7:0]       frm;
  logic                  [7:0]       ref_clk;
  sgh_pkg::sgh_ctl_s     [7:0]       ctl_o;
  sgh_pkg::sgh_rx_out_s  [7:0]       rx_o;
  logic                  [7:0]       div_o;
  int failures = 0;
  int compares = 0;
  always #12.5 clock_i = ~clock_i;
  sgh_bank dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .frm_i(frm), .pll_reference_clock_i(ref_clk),
    .ctl_o(ctl_o), .rx_o(rx_o), .divided_reference_output_o(div_o));
  sgh_frm_model p_u (.clock_i(clock_i), .frm_o(frm), .ref_clk_o(ref_clk));
  // verdict, reached from the main sequence or the watchdog
  task end_sim;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one-cycle write strobe
  task wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clock_i);
    wr_i <= 1'b1; addr_i <= a; wdata_i <= d;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  // one-cycle read strobe; data sampled in the following cycle only
  task rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clock_i);
    rd_i <= 1'b1; addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  // expected decoded control worked out from the bit meanings
  function automatic logic [9:0] ectl(logic [7:0] m, logic [7:0] h, logic c, logic l);
    return {~m[0], m[2], ~m[0] & m[2], ~c & m[4], ~c & m[5] & m[2],
            c & (m[7] | (m[6] & l)), h[0], ~h[1], h[3], h[2]};
  endfunction
  // clocks spent until the divided output reaches level v (bounded)
  task wlv(input logic v, inout int n);
    while (div_o[0] !== v && n < 5000) begin
      @(posedge clock_i);
      #1;
      n++;
    end
  endtask
  // watchdog: whole run is well under 20000 cycles
  initial begin
    #(25 * 40000);
    failures++;
    end_sim;
  end
  logic [7:0] d, m, bf;
  logic [3:0] ln;
  logic [1:0] fu;
  logic       c;
  int         n;
  logic [7:0] tm [7] = '{8'h00, 8'h01, 8'h34, 8'h34, 8'h40, 8'h40, 8'h80};
  logic [7:0] th [7] = '{8'h00, 8'h04, 8'h08, 8'h05, 8'h01, 8'h00, 8'h00};
  logic [6:0] tc = 7'b1111000;
  logic [6:0] tl = 7'b0010000;
  logic [7:0] nm [8] = '{8'h02, 8'h00, 8'h08, 8'h02, 8'h00, 8'h01, 8'h24, 8'h26};
  logic [3:0] nn [8] = '{4'h0, 4'h0, 4'h5, 4'h3, 4'h9, 4'h6, 4'h0, 4'h7};
  logic [7:0] ncp = 8'b00000111;
  initial begin
    repeat (10) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    // reset values, framer isolation, unmapped offset
    rd(5'h00, d); chk("mode_rst", 10'h0, d);
    rd(5'h1d, d); chk("hwy_rst", 10'h0, d);
    wr(5'h04, 8'ha5); rd(5'h04, d); chk("f1_mode", 10'ha5, d);
    // write then read with no gap between the strobes
    @(posedge clock_i);
    wr_i <= 1'b1; addr_i <= 5'h00; wdata_i <= 8'h5a;
    @(posedge clock_i);
    wr_i <= 1'b0; rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 chk("b2b_read", 10'h5a, rdata_o);
    rd(5'h0c, d); chk("f3_mode", 10'h0, d);
    rd(5'h0b, d); chk("unmapped", 10'h0, d);
    // decoded control over a table of modes, formats and alarm levels
    for (int i = 0; i < 7; i++) begin
      p_u.set_lvl(0, tc[i], tl[i]);
      wr(5'h01, th[i]);
      wr(5'h00, tm[i]);
      repeat (2) @(posedge clock_i);
      #1 chk("ctl", ectl(tm[i], th[i], tc[i], tl[i]), ctl_o[0]);
    end
    chk("f5_ctl", 10'h204, ctl_o[5]);
    // receive nibble path on framer 0, rate 8 mbit/s for the split rows
    wr(5'h01, 8'h04);
    bf = 8'h00;
    for (int i = 0; i < 8; i++) begin
      m = nm[i];
      c = ncp[i];
      p_u.set_lvl(0, c, 1'b0);
      wr(5'h00, m);
      fu = (!c && m[5] && m[2]) ? 2'h2 : 2'h1;
      ln = nn[i];
      if (!m[0] && m[1] && ((c && ln == 4'h0) || (!c && fu != 2'h0))) ln = 4'hf;
      if (!m[0] && !m[3]) bf = {4'h0, nn[i]};
      p_u.send(0, nn[i], 2'h2, 2'h1);
      #1 chk("rx_valid", 10'h1, rx_o[0].valid);
      chk("line_nib", ln, rx_o[0].line_nib);
      chk("fg_used", fu, rx_o[0].fg_used);
      if (!c) chk("voice", !m[0], rx_o[0].voice);
      rd(5'h02, d); chk("sig_buf", bf[3:0], d[3:0]);
    end
    // data channel under ds1 stomp stays untouched and unbuffered
    p_u.send(0, 4'h4, 2'h0, 2'h0);
    #1 chk("data_voice", 10'h0, rx_o[0].voice);
    chk("data_nib", 10'h4, rx_o[0].line_nib);
    rd(5'h02, d); chk("data_buf", bf[3:0], d[3:0]);
    // divided reference period: 193 or 256 edges of 8 clocks each
    for (int k = 0; k < 2; k++) begin
      p_u.set_lvl(0, k[0], 1'b0);
      wr(5'h01, 8'h00);
      n = 0; wlv(1'b0, n); wlv(1'b1, n);
      n = 0; wlv(1'b0, n); wlv(1'b1, n);
      chk("div_period", 10'h1, (n >= (k ? 2045 : 1541)) && (n <= (k ? 2051 : 1547)));
    end
    end_sim;
  end
endmodule
